// File: design/ifd_defs.svh
// constants for the instruction field decoder
// assumes inclusion by bare name from the design files
`ifndef IFD_DEFS_SVH
`define IFD_DEFS_SVH
// instruction word field positions
`define IFD_FN_HI    15
`define IFD_FN_LO    11
`define IFD_MD_HI    10
`define IFD_MD_LO    8
`define IFD_DP_HI    7
`define IFD_DP_LO    0
`define IFD_DP_SIGN  7
// address modes
`define IFD_MD_ABS   3'h0
`define IFD_MD_REL   3'h1
// function codes
`define IFD_FN_SHIFT 5'h0C
`define IFD_FN_BLKA  5'h1C
`define IFD_FN_BLKB  5'h1D
`define IFD_FN_DADD  5'h08
`define IFD_FN_DSUB  5'h09
`define IFD_FN_MUL   5'h0A
`define IFD_FN_DIV   5'h0B
// named locations in fast storage
`define IFD_LOC_P    4'h0
`define IFD_LOC_B    4'h1
`define IFD_LOC_C    4'h2
`define IFD_LOC_G    4'h3
`define IFD_LOC_E    4'h4
`define IFD_LOC_A    4'h5
// shift descriptor: bit 3 set means no shift
`define IFD_G_NOSH   3
// reset values
`define IFD_WORD_RST 16'h0000
`endif

// File: design/ifd_pkg.sv
// types for the instruction field decoder
// assumes nothing outside itself
package ifd_pkg;
	// fields held for one instruction
	typedef struct packed {
		logic [4:0] func;
		logic [2:0] mode;
		logic [7:0] disp;
	} ifd_fields_t;
	// operand access request
	typedef struct packed {
		logic        wr;
		logic [15:0] addr;
		logic [15:0] wdata;
	} ifd_opnd_t;
	// instruction sequencing
	typedef enum logic [0:0] {IFD_S_IDLE, IFD_S_EXEC} ifd_state_t;
	// core transfer handshake
	typedef enum logic [1:0] {IFD_C_IDLE, IFD_C_REQ, IFD_C_REL} ifd_core_t;
endpackage

// File: design/ifd_decoder.sv
// instruction field decoder with fast storage and core handshake
// assumes one clock; core card answers a four-phase req/ack
//
// The implementer's own choices: strobed register access and the address map.
`include "ifd_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module ifd_decoder #(
	parameter int DATA_W     = 16,
	parameter int FAST_DEPTH = 16
) (
	// clock and reset
	input  wire logic                i_clock,
	input  wire logic                i_rst_n,
	// fetched instruction
	input  wire logic                i_instr_valid,
	input  wire logic [DATA_W-1:0]   i_instr_word,
	input  wire logic [DATA_W-1:0]   i_instr_addr,
	output logic                     o_instr_ready,
	input  wire logic                i_exec_done,
	// decoded fields and flags
	output ifd_pkg::ifd_fields_t     o_fields,
	output logic [31:0]              o_func_sel,
	output logic [7:0]               o_mode_sel,
	output logic [DATA_W-1:0]        o_abs_addr,
	output logic [DATA_W-1:0]        o_rel_addr,
	output logic [DATA_W-1:0]        o_eff_addr,
	output logic                     o_disp_signed,
	output logic                     o_is_shift,
	output logic [7:0]               o_shift_sel,
	output logic                     o_no_shift,
	output logic                     o_blk_a,
	output logic                     o_blk_b,
	output logic                     o_dbl_add,
	output logic                     o_dbl_sub,
	output logic                     o_mul,
	output logic                     o_div,
	// named registers
	output logic [DATA_W-1:0]        o_prog_addr,
	output logic [DATA_W-1:0]        o_base_b,
	output logic [DATA_W-1:0]        o_base_c,
	output logic [DATA_W-1:0]        o_shift_desc,
	output logic [DATA_W-1:0]        o_ext_acc,
	output logic [DATA_W-1:0]        o_acc,
	// operand access
	input  wire logic                i_opnd_req,
	input  wire ifd_pkg::ifd_opnd_t  i_opnd,
	output logic                     o_opnd_ready,
	output logic                     o_opnd_done,
	output logic [DATA_W-1:0]        o_opnd_rdata,
	// core memory card
	output logic                     o_core_req,
	output logic                     o_core_wr,
	output logic [DATA_W-1:0]        o_core_addr,
	output logic [DATA_W-1:0]        o_core_wdata,
	input  wire logic                i_core_ack,
	input  wire logic [DATA_W-1:0]   i_core_rdata
);
	////////////////////////////////////////////////////////////////
	// elaboration check
	generate
		if (DATA_W != 16 || FAST_DEPTH != 16) begin : g_bad
			$error("ifd_decoder supports only 16-bit, 16 words");
		end
	endgenerate

	////////////////////////////////////////////////////////////////
	// helpers
	// true for an address held in fast storage
	function automatic logic is_fast(input logic [DATA_W-1:0] a);
		is_fast = (a[DATA_W-1:4] == '0);
	endfunction

	// sign extend an eight bit displacement
	function automatic logic [DATA_W-1:0] sext(input logic [7:0] d);
		sext = {{(DATA_W-8){d[`IFD_DP_SIGN]}}, d};
	endfunction

	////////////////////////////////////////////////////////////////
	// instruction hold
	ifd_pkg::ifd_state_t  st_r;          // sequencing state
	ifd_pkg::ifd_state_t  st_nxt;        // next state
	ifd_pkg::ifd_fields_t hold_r;        // held fields
	logic [DATA_W-1:0]    iaddr_r;       // instruction address
	wire                  take;          // instruction accepted
	ifd_pkg::ifd_fields_t fld_in;        // incoming fields

	assign o_instr_ready = (st_r == ifd_pkg::IFD_S_IDLE);
	assign take          = i_instr_valid && o_instr_ready;
	// split the word into its three fields
	assign fld_in.func = i_instr_word[`IFD_FN_HI:`IFD_FN_LO];
	// mode field
	assign fld_in.mode = i_instr_word[`IFD_MD_HI:`IFD_MD_LO];
	// displacement or channel
	assign fld_in.disp = i_instr_word[`IFD_DP_HI:`IFD_DP_LO];

	// state decode
	always_comb begin
		st_nxt = st_r;
		case (st_r)
			ifd_pkg::IFD_S_IDLE: begin
				if (take) begin
					st_nxt = ifd_pkg::IFD_S_EXEC;
				end
			end
			ifd_pkg::IFD_S_EXEC: begin
				if (i_exec_done) begin
					st_nxt = ifd_pkg::IFD_S_IDLE;
				end
			end
			default: st_nxt = ifd_pkg::IFD_S_IDLE;
		endcase
	end

	// latch all fields at once, hold till done
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_r    <= ifd_pkg::IFD_S_IDLE;
			hold_r  <= '0;
			iaddr_r <= `IFD_WORD_RST;
		end else begin
			st_r <= st_nxt;
			if (take) begin
				hold_r  <= fld_in;
				iaddr_r <= i_instr_addr;
			end
		end
	end
	assign o_fields = hold_r;

	////////////////////////////////////////////////////////////////
	// registered decode of the incoming word
	wire [DATA_W-1:0] abs_in;            // zero extended displacement
	wire [DATA_W-1:0] rel_in;            // relative operand address
	wire              sgn_in;            // displacement signed

	// clear bits 8 to 15
	assign abs_in = {{(DATA_W-8){1'b0}}, fld_in.disp};
	// sign extend and add instruction address
	assign rel_in = i_instr_addr + sext(fld_in.disp);
	// signed for relative mode and shift counts
	assign sgn_in = (fld_in.mode == `IFD_MD_REL) ||
		(fld_in.func == `IFD_FN_SHIFT);

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_func_sel    <= '0;
			o_mode_sel    <= '0;
			o_abs_addr    <= `IFD_WORD_RST;
			o_rel_addr    <= `IFD_WORD_RST;
			o_eff_addr    <= `IFD_WORD_RST;
			o_disp_signed <= 1'b0;
		end else if (take) begin
			// one select line per function
			o_func_sel    <= 32'h1 << fld_in.func;
			// one select line per mode
			o_mode_sel    <= 8'h1 << fld_in.mode;
			o_abs_addr    <= abs_in;
			o_rel_addr    <= rel_in;
			// relative mode uses the added address
			o_eff_addr    <= (fld_in.mode == `IFD_MD_REL) ?
				rel_in : abs_in;
			o_disp_signed <= sgn_in;
		end
	end

	// operation flags from the held function
	assign o_blk_a   = (hold_r.func == `IFD_FN_BLKA);
	assign o_blk_b   = (hold_r.func == `IFD_FN_BLKB);
	assign o_dbl_add = (hold_r.func == `IFD_FN_DADD);
	assign o_dbl_sub = (hold_r.func == `IFD_FN_DSUB);
	// native multiply and divide
	assign o_mul     = (hold_r.func == `IFD_FN_MUL);
	assign o_div     = (hold_r.func == `IFD_FN_DIV);
	assign o_is_shift = (hold_r.func == `IFD_FN_SHIFT);

	////////////////////////////////////////////////////////////////
	// fast storage, sixteen flip-flop words
	logic [DATA_W-1:0] fast_q [FAST_DEPTH]; // word outputs
	wire               fast_wr;          // fast write strobe
	wire               opnd_take;        // operand request taken
	wire               opnd_fast;        // request in fast range

	assign opnd_take = i_opnd_req && o_opnd_ready;
	// fast range served locally
	assign opnd_fast = opnd_take && is_fast(i_opnd.addr);
	assign fast_wr   = opnd_fast && i_opnd.wr;

	genvar g;
	generate
		for (g = 0; g < FAST_DEPTH; g++) begin : g_fast
			logic [DATA_W-1:0] loc_r;    // one location
			// p gets instruction address less one
			if (g == 0) begin : g_p
				always_ff @(posedge i_clock or negedge i_rst_n) begin
					if (!i_rst_n) begin
						loc_r <= `IFD_WORD_RST;
					end else if (take) begin
						loc_r <= i_instr_addr - 16'h0001;
					end else if (fast_wr && i_opnd.addr[3:0] == g) begin
						loc_r <= i_opnd.wdata;
					end
				end
			end else begin : g_w
				always_ff @(posedge i_clock or negedge i_rst_n) begin
					if (!i_rst_n) begin
						loc_r <= `IFD_WORD_RST;
					end else if (fast_wr && i_opnd.addr[3:0] == g) begin
						loc_r <= i_opnd.wdata;
					end
				end
			end
			assign fast_q[g] = loc_r;
		end
	endgenerate

	// named registers by location
	assign o_prog_addr  = fast_q[`IFD_LOC_P];
	assign o_base_b     = fast_q[`IFD_LOC_B];
	assign o_base_c     = fast_q[`IFD_LOC_C];
	assign o_shift_desc = fast_q[`IFD_LOC_G];
	assign o_ext_acc    = fast_q[`IFD_LOC_E];
	assign o_acc        = fast_q[`IFD_LOC_A];

	// shift variant from the descriptor
	assign o_no_shift  = o_shift_desc[`IFD_G_NOSH];
	assign o_shift_sel = (o_is_shift && !o_no_shift) ?
		(8'h1 << o_shift_desc[2:0]) : 8'h00;

	////////////////////////////////////////////////////////////////
	// operand access and core handshake
	ifd_pkg::ifd_core_t cst_r;           // core state
	ifd_pkg::ifd_core_t cst_nxt;         // next core state

	assign o_opnd_ready = (cst_r == ifd_pkg::IFD_C_IDLE);
	assign o_core_req   = (cst_r == ifd_pkg::IFD_C_REQ);

	// req held until ack, then wait for ack to fall
	always_comb begin
		cst_nxt = cst_r;
		case (cst_r)
			ifd_pkg::IFD_C_IDLE: begin
				if (opnd_take && !opnd_fast) begin
					cst_nxt = ifd_pkg::IFD_C_REQ;
				end
			end
			ifd_pkg::IFD_C_REQ: begin
				if (i_core_ack) begin
					cst_nxt = ifd_pkg::IFD_C_REL;
				end
			end
			ifd_pkg::IFD_C_REL: begin
				if (!i_core_ack) begin
					cst_nxt = ifd_pkg::IFD_C_IDLE;
				end
			end
			default: cst_nxt = ifd_pkg::IFD_C_IDLE;
		endcase
	end

	// core address, data and answer registers
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cst_r        <= ifd_pkg::IFD_C_IDLE;
			o_core_wr    <= 1'b0;
			o_core_addr  <= `IFD_WORD_RST;
			o_core_wdata <= `IFD_WORD_RST;
			o_opnd_done  <= 1'b0;
			o_opnd_rdata <= `IFD_WORD_RST;
		end else begin
			cst_r       <= cst_nxt;
			o_opnd_done <= opnd_fast ||
				(o_core_req && i_core_ack);
			if (opnd_take && !opnd_fast) begin
				o_core_wr    <= i_opnd.wr;
				o_core_addr  <= i_opnd.addr;
				o_core_wdata <= i_opnd.wdata;
			end
			if (opnd_fast) begin
				o_opnd_rdata <= fast_q[i_opnd.addr[3:0]];
			end else if (o_core_req && i_core_ack) begin
				o_opnd_rdata <= i_core_rdata;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// assertions
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rst_n);

	// core answer seen while requesting
	sequence s_ack_seen;
		o_core_req && i_core_ack;
	endsequence
	// answer returned and request released
	sequence s_released;
		!o_core_req && o_opnd_done;
	endsequence

	property p_latch;
		take |=> o_fields == $past(fld_in);
	endproperty
	a_latch: assert property (p_latch)
		else $error("fields not latched together");

	property p_hold;
		(st_r == ifd_pkg::IFD_S_EXEC) && !i_exec_done
			|=> $stable(o_fields);
	endproperty
	a_hold: assert property (p_hold)
		else $error("fields changed during instruction");

	property p_func_sel;
		take |=> o_func_sel[o_fields.func] && $onehot(o_func_sel);
	endproperty
	a_func_sel: assert property (p_func_sel)
		else $error("function select wrong");

	property p_mode_sel;
		take |=> o_mode_sel[o_fields.mode] && $onehot(o_mode_sel);
	endproperty
	a_mode_sel: assert property (p_mode_sel)
		else $error("mode select wrong");

	property p_abs;
		take |=> o_abs_addr == {8'h00, o_fields.disp};
	endproperty
	a_abs: assert property (p_abs)
		else $error("absolute address not zero extended");

	property p_rel;
		take |=> o_rel_addr == iaddr_r + sext(o_fields.disp);
	endproperty
	a_rel: assert property (p_rel)
		else $error("relative address wrong");

	property p_pload;
		take |=> o_prog_addr == $past(i_instr_addr) - 16'h0001;
	endproperty
	a_pload: assert property (p_pload)
		else $error("program address not one less");

	property p_fast;
		opnd_fast |=> o_opnd_done && !o_core_req;
	endproperty
	a_fast: assert property (p_fast)
		else $error("fast access started core transfer");

	property p_core_hold;
		o_core_req && !i_core_ack |=> o_core_req;
	endproperty
	a_core_hold: assert property (p_core_hold)
		else $error("core request dropped before ack");

	property p_core_done;
		s_ack_seen |=> s_released;
	endproperty
	a_core_done: assert property (p_core_done)
		else $error("core answer not returned");
endmodule
`default_nettype wire

// File: design/_unused_placeholder_none.sv
// intentionally empty
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// File: testbench/ifd_core_card.sv
// behavioural core memory card facing the decoder
// assumes a four-phase req/ack on the decoder clock
`timescale 1ns/1ps
`default_nettype none
module ifd_core_card (
	// clock and reset
	input  wire logic        i_clock,
	input  wire logic        i_rst_n,
	// request from the decoder
	input  wire logic        i_req,
	input  wire logic        i_wr,
	input  wire logic [15:0] i_addr,
	input  wire logic [15:0] i_wdata,
	// answer delay chosen by the bench
	input  wire logic [7:0]  i_delay,
	// answer to the decoder
	output logic             o_ack,
	output logic [15:0]      o_rdata
);
	logic [15:0] mem_r [0:255]; // small image of the card
	logic [7:0]  wait_r;        // cycles spent before answering
	////////////////////////////////////////////////////////////////////
	// answer after i_delay cycles, let go when req falls
	always @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_ack   <= 1'b0;
			o_rdata <= 16'h0000;
			wait_r  <= 8'h00;
		end else if (i_req && !o_ack) begin
			if (wait_r >= i_delay) begin
				o_ack  <= 1'b1;
				wait_r <= 8'h00;
				if (i_wr)
					mem_r[i_addr[7:0]] <= i_wdata;
				o_rdata <= i_wr ? ~o_rdata : mem_r[i_addr[7:0]];
			end else begin
				wait_r <= wait_r + 8'h01; // slow card still busy
			end
		end else if (o_ack && !i_req) begin
			o_ack   <= 1'b0;
			o_rdata <= ~o_rdata; // released bus shows no stale word
		end
	end
	// card starts cleared
	initial begin
		for (int i = 0; i < 256; i++)
			mem_r[i] = 16'h0000;
	end
endmodule
`default_nettype wire

// File: testbench/instruction_field_decoder_test.sv
// self-checking bench for the instruction field decoder
// assumes ifd_pkg, the decoder and the core card compiled first
`include "ifd_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module instruction_field_decoder_test;
	// rows: word, instruction address, expected operand address
	logic [47:0] rows [10] = '{48'h6085_6003_0085, 48'h4106_6003_6009,
		48'h4980_6003_5F83, 48'h52FF_0100_00FF, 48'h5B00_0100_0000,
		48'hE47F_0100_007F, 48'hED01_0100_0001, 48'hFE10_0100_0010,
		48'h0720_0100_0020, 48'h09FF_0000_FFFF};
	// stimulus
	logic        i_clock = 1'b0;
	logic        i_rst_n = 1'b0;
	logic        i_instr_valid = 1'b0;
	logic [15:0] i_instr_word = 16'h0000;
	logic [15:0] i_instr_addr = 16'h0000;
	logic        i_exec_done = 1'b0;
	logic        i_opnd_req = 1'b0;
	ifd_pkg::ifd_opnd_t i_opnd = '0;
	logic [7:0]  delay = 8'h00;
	// observed
	ifd_pkg::ifd_fields_t o_fields;
	logic [31:0] o_func_sel;
	logic [7:0]  o_mode_sel, o_shift_sel;
	logic [15:0] o_abs_addr, o_rel_addr, o_eff_addr, o_opnd_rdata;
	logic [15:0] named [6];      // fast locations 0 to 5
	logic [15:0] o_core_addr, o_core_wdata, core_rdata, last_addr;
	logic        o_instr_ready, o_disp_signed, o_is_shift, o_no_shift;
	logic        o_blk_a, o_blk_b, o_dbl_add, o_dbl_sub, o_mul, o_div;
	logic        o_opnd_ready, o_opnd_done, o_core_req, o_core_wr;
	logic        core_ack, core_seen;
	int          err_count = 0;
	int          checks_done = 0;
	////////////////////////////////////////////////////////////////////
	// 25 MHz clock
	always #20 i_clock = ~i_clock;
	// note any core transfer and its address
	always @(posedge i_clock) begin
		if (!i_rst_n) begin
			core_seen <= 1'b0;
			last_addr <= 16'h0000;
		end else if (o_core_req) begin
			core_seen <= 1'b1;
			last_addr <= o_core_addr;
		end
	end
	ifd_decoder dut (.i_clock(i_clock), .i_rst_n(i_rst_n),
		.i_instr_valid(i_instr_valid), .i_instr_word(i_instr_word),
		.i_instr_addr(i_instr_addr), .o_instr_ready(o_instr_ready),
		.i_exec_done(i_exec_done), .o_fields(o_fields),
		.o_func_sel(o_func_sel), .o_mode_sel(o_mode_sel),
		.o_abs_addr(o_abs_addr), .o_rel_addr(o_rel_addr),
		.o_eff_addr(o_eff_addr), .o_disp_signed(o_disp_signed),
		.o_is_shift(o_is_shift), .o_shift_sel(o_shift_sel),
		.o_no_shift(o_no_shift), .o_blk_a(o_blk_a), .o_blk_b(o_blk_b),
		.o_dbl_add(o_dbl_add), .o_dbl_sub(o_dbl_sub), .o_mul(o_mul),
		.o_div(o_div), .o_prog_addr(named[0]), .o_base_b(named[1]),
		.o_base_c(named[2]), .o_shift_desc(named[3]),
		.o_ext_acc(named[4]), .o_acc(named[5]),
		.i_opnd_req(i_opnd_req), .i_opnd(i_opnd),
		.o_opnd_ready(o_opnd_ready), .o_opnd_done(o_opnd_done),
		.o_opnd_rdata(o_opnd_rdata), .o_core_req(o_core_req),
		.o_core_wr(o_core_wr), .o_core_addr(o_core_addr),
		.o_core_wdata(o_core_wdata), .i_core_ack(core_ack),
		.i_core_rdata(core_rdata));
	ifd_core_card card (.i_clock(i_clock), .i_rst_n(i_rst_n),
		.i_req(o_core_req), .i_wr(o_core_wr), .i_addr(o_core_addr),
		.i_wdata(o_core_wdata), .i_delay(delay), .o_ack(core_ack),
		.o_rdata(core_rdata));
	////////////////////////////////////////////////////////////////////
	// compare and count
	task automatic chk(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// verdict and end of run
	task automatic report_and_stop;
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// present one word, taken at the second edge
	task automatic instr(input logic [15:0] w, input logic [15:0] a);
		@(posedge i_clock);
		i_instr_valid <= 1'b1;
		i_instr_word  <= w;
		i_instr_addr  <= a;
		@(posedge i_clock);
		i_instr_valid <= 1'b0;
		#1;
	endtask
	// end the held instruction
	task automatic finish_instr;
		@(posedge i_clock);
		i_exec_done <= 1'b1;
		@(posedge i_clock);
		i_exec_done <= 1'b0;
		#1;
		chk("instr_ready", o_instr_ready, 1);
	endtask
	// one operand access; n counts edges from take to done
	task automatic opnd(input logic wr, input logic [15:0] a,
		input logic [15:0] d, output logic [15:0] q, output int n);
		n = 0;
		while (o_opnd_ready !== 1'b1 && n < 50) begin
			@(posedge i_clock);
			#1;
			n++;
		end
		@(posedge i_clock);
		i_opnd_req <= 1'b1;
		i_opnd     <= {wr, a, d};
		@(posedge i_clock);
		i_opnd_req <= 1'b0;
		#1;
		n = 0;
		while (o_opnd_done !== 1'b1 && n < 50) begin
			@(posedge i_clock);
			#1;
			n++;
		end
		q = o_opnd_rdata;
		if (n >= 50)
			err_count++;
	endtask
	////////////////////////////////////////////////////////////////////
	// watchdog
	initial begin
		repeat (20000) @(posedge i_clock);
		err_count++;
		report_and_stop;
	end
	// main sequence
	initial begin
		logic [15:0] w, v, q;
		logic [6:0]  flg, xf;
		logic [4:0]  fc;
		int          n;
		repeat (3) @(posedge i_clock);
		#1;
		chk("rst_instr_ready", o_instr_ready, 1);
		chk("rst_opnd_ready", o_opnd_ready, 1);
		chk("rst_core_req", o_core_req, 0);
		chk("rst_fields", o_fields, 0);
		@(posedge i_clock);
		i_rst_n <= 1'b1;
		// ordinary decodes from the table
		foreach (rows[i]) begin
			w = rows[i][47:32];
			instr(w, rows[i][31:16]);
			v = rows[i][31:16] + {{8{w[7]}}, w[7:0]};
			chk("fields", o_fields, w);
			chk("mode_sel", o_mode_sel, 8'h01 << w[10:8]);
			chk("abs_addr", o_abs_addr, {8'h00, w[7:0]});
			chk("rel_addr", o_rel_addr, v);
			chk("eff_addr", o_eff_addr, rows[i][15:0]);
			v = rows[i][31:16] - 16'h0001;
			chk("prog_addr", named[0], v);
			v = {15'h0000, w[10:8] == 3'h1 || w[15:11] == `IFD_FN_SHIFT};
			chk("disp_signed", o_disp_signed, v);
			chk("busy", o_instr_ready, 0);
			finish_instr;
		end
		// every function code
		for (int f = 0; f < 32; f++) begin
			fc = f[4:0];
			instr({fc, 3'h0, 8'h10}, 16'h0200);
			chk("func_sel", o_func_sel, 32'h1 << f);
			flg = {o_is_shift, o_blk_a, o_blk_b, o_dbl_add,
				o_dbl_sub, o_mul, o_div};
			xf = {fc == `IFD_FN_SHIFT, fc == `IFD_FN_BLKA,
				fc == `IFD_FN_BLKB, fc == `IFD_FN_DADD, fc == `IFD_FN_DSUB,
				fc == `IFD_FN_MUL, fc == `IFD_FN_DIV};
			chk("op_flags", flg, xf);
			finish_instr;
		end
		// word offered while busy is ignored
		instr(16'h4106, 16'h6003);
		@(posedge i_clock);
		i_instr_valid <= 1'b1;
		i_instr_word  <= 16'hFE10;
		repeat (2) @(posedge i_clock);
		i_instr_valid <= 1'b0;
		#1;
		chk("held_fields", o_fields, 16'h4106);
		finish_instr;
		// fast storage, named registers, no core traffic
		for (int i = 0; i < 16; i++) begin
			opnd(1'b1, i[15:0], 16'h5A00 | i[15:0], q, n);
			chk("fast_lat", n, 0);
			if (i < 6) chk("named", named[i], 16'h5A00 | i[15:0]);
		end
		for (int i = 0; i < 16; i++) begin
			opnd(1'b0, i[15:0], 16'h0000, q, n);
			chk("fast_rd", q, 16'h5A00 | i[15:0]);
		end
		chk("core_idle", core_seen, 0);
		// shift descriptor: eight variants then no shift
		instr({`IFD_FN_SHIFT, 3'h0, 8'h00}, 16'h0300);
		for (int g = 0; g < 9; g++) begin
			opnd(1'b1, 16'h0003, g[15:0], q, n);
			v = (g < 8) ? 16'h0001 << g : 16'h0000;
			chk("shift_sel", o_shift_sel, v);
			chk("no_shift", o_no_shift, g == 8);
		end
		finish_instr;
		// first core location, slow then prompt card
		delay <= 8'h05;
		opnd(1'b1, 16'h0010, 16'hC3A5, q, n);
		chk("core_used", core_seen, 1);
		chk("core_addr", last_addr, 16'h0010);
		chk("slow_lat", n, 7);
		delay <= 8'h00;
		opnd(1'b0, 16'h0010, 16'h0000, q, n);
		chk("core_rd", q, 16'hC3A5);
		chk("fast_card_lat", n, 2);
		report_and_stop;
	end
endmodule
`default_nettype wire
